/* File: hw/pgr_pkg.sv */
package pgr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] PGR_OFS_PG_CTRL1 = 8'h15;
  localparam logic [7:0] PGR_OFS_PG_CTRL2 = 8'h16;
  localparam logic [7:0] PGR_OFS_FAULT = 8'h17;
  localparam logic [7:0] PGR_OFS_RESET = 8'h18;
  localparam logic [7:0] PGR_OFS_INT_TOP1 = 8'h19;

  // ==========================================================
  // Field positions
  localparam int PGR_C2_TWARN_BIT = 2;
  localparam int PGR_C2_FGATE_BIT = 1;
  localparam int PGR_C2_MODE_BIT = 0;
  localparam int PGR_C1_POL_BIT = 7;
  localparam int PGR_RST_BIT = 0;
  localparam int PGR_INT_PG_BIT = 7;
  localparam int PGR_NRAILS = 4;

  // ==========================================================
  // Reset values
  localparam logic [7:0] PGR_RST_PG_CTRL1 = 8'h73;
  localparam logic [2:0] PGR_RST_PG_CTRL2 = 3'h4;
  localparam logic [3:0] PGR_RST_FAULT = 4'h0;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pgr_req_type;

  typedef struct packed {
    logic [3:0] valid;
    logic       twarn;
  } pgr_mon_type;

  typedef enum logic [2:0] {
    PGR_ST_START = 3'b001,
    PGR_ST_RUN = 3'b010,
    PGR_ST_RELOAD = 3'b100
  } pgr_state_type;

endpackage

/* File: hw/pgr_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for the analogue monitor inputs
module pgr_sync
  import pgr_pkg::*;
#(
  parameter int W = 5
) (
  // Clocking
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else if (clk_en_i) begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // pgr_sync

/* File: hw/pgr_power_good.sv */
`timescale 1ns/1ps
// Functional notes
// - Thermal warning forces output inactive when enabled by control two bit 2, in either mode
// - Select zero: output follows live rail status
// - Select one: output inactive while latch set
// - Mode bit: zero gated, one continuous
// - Selected rail going invalid while output active sets its latch
// - Write-one clears latch only if rail valid
// - Fault latches at bits 3:0, rest zero
// - Reset bit restores registers, reloads, resets interface
// - Reset bit clears itself, reads zero
// - Control two: bits 2:0 used, 7:3 zero
// - Per-rail enables select monitored rails
// - Polarity bit inverts the output level
// - Active-to-inactive drop sets write-one-clear flag
module pgr_power_good
  import pgr_pkg::*;
(
  // Clocking
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Register port from the serial interface
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Monitors: rail valid {linreg1, linreg0, buck_b, buck_a}, thermal warning
  input wire logic [3:0] rail_valid_i,
  input wire logic thermal_warning_i,
  // System side
  output logic power_good_out_o,
  output logic otp_reload_o,
  output logic serial_if_reset_o
);

  pgr_req_type req;
  pgr_mon_type mon;
  pgr_state_type state_r;
  logic [7:0] ctrl1_r;
  logic [2:0] ctrl2_r;
  logic [3:0] fault_r;
  logic drop_flag_r;
  logic pg_active_r;
  logic soft_rst;
  logic pg_active_nxt;
  logic [3:0] monitored;
  logic live_ok;

  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

  function automatic logic hit(input pgr_req_type r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // ==========================================================
  // Monitor synchronisers
  pgr_sync #(
    .W(5)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .async_i({rail_valid_i, thermal_warning_i}),
    .sync_o(mon)
  );

  // ==========================================================
  // Software reset
  // Reset command decode
  assign soft_rst = hit(req, PGR_OFS_RESET) && reg_wdata_i[PGR_RST_BIT];

  // Pulses last one cycle; the bit is never stored so it reads zero
  // Self clearing
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      otp_reload_o <= 1'b0;
      serial_if_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      otp_reload_o <= soft_rst;
      serial_if_reset_o <= soft_rst;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl1_r <= PGR_RST_PG_CTRL1;
      ctrl2_r <= PGR_RST_PG_CTRL2;
    end else if (clk_en_i) begin
      if (soft_rst) begin
        ctrl1_r <= PGR_RST_PG_CTRL1;
        ctrl2_r <= PGR_RST_PG_CTRL2;
      end else begin
        if (hit(req, PGR_OFS_PG_CTRL1)) begin
          ctrl1_r <= reg_wdata_i;
        end
        if (hit(req, PGR_OFS_PG_CTRL2)) begin
          ctrl2_r <= reg_wdata_i[2:0];
        end
      end
    end
  end

  // ==========================================================
  // Start-up sequencing for gated mode
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= PGR_ST_START;
    end else if (clk_en_i) begin
      case (state_r)
        PGR_ST_START: begin
          if (soft_rst) begin
            state_r <= PGR_ST_RELOAD;
          end else if (live_ok) begin
            state_r <= PGR_ST_RUN;
          end
        end
        PGR_ST_RUN: begin
          if (soft_rst) begin
            state_r <= PGR_ST_RELOAD;
          end
        end
        PGR_ST_RELOAD: begin
          state_r <= PGR_ST_START;
        end
        default: begin
          state_r <= PGR_ST_START;
        end
      endcase
    end
  end

  // ==========================================================
  // Power-good evaluation
  // Rail selection
  assign monitored = ctrl1_r[3:0];
  assign live_ok = &(mon.valid | ~monitored);

  always_comb begin
    pg_active_nxt = live_ok;
    if (ctrl2_r[PGR_C2_FGATE_BIT]) begin
      pg_active_nxt = ~|fault_r;
    end
    if (ctrl2_r[PGR_C2_TWARN_BIT] && mon.twarn) begin
      pg_active_nxt = 1'b0;
    end
    // Gated mode holds off until start-up completes
    if (!ctrl2_r[PGR_C2_MODE_BIT] && (state_r != PGR_ST_RUN)) begin
      pg_active_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pg_active_r <= 1'b0;
    end else if (clk_en_i) begin
      pg_active_r <= pg_active_nxt;
    end
  end

  assign power_good_out_o = pg_active_r ^ ctrl1_r[PGR_C1_POL_BIT];

  // ==========================================================
  // Fault latches; a new fault wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_r <= PGR_RST_FAULT;
    end else if (clk_en_i) begin
      if (soft_rst) begin
        fault_r <= PGR_RST_FAULT;
      end else begin
        for (int i = 0; i < PGR_NRAILS; i++) begin
          if (monitored[i] && !mon.valid[i] && pg_active_r) begin
            fault_r[i] <= 1'b1;
          end else if (hit(req, PGR_OFS_FAULT) && reg_wdata_i[i] && mon.valid[i]) begin
            fault_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================
  // Drop flag
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      drop_flag_r <= 1'b0;
    end else if (clk_en_i) begin
      if (pg_active_r && !pg_active_nxt) begin
        drop_flag_r <= 1'b1;
      end else if (soft_rst) begin
        drop_flag_r <= 1'b0;
      end else if (hit(req, PGR_OFS_INT_TOP1) && reg_wdata_i[PGR_INT_PG_BIT]) begin
        drop_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read data, registered
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      if (req.rd) begin
        case (req.addr)
          PGR_OFS_PG_CTRL1: reg_rdata_o <= ctrl1_r;
          PGR_OFS_PG_CTRL2: reg_rdata_o <= {5'h00, ctrl2_r};
          PGR_OFS_FAULT: reg_rdata_o <= {4'h0, fault_r};
          PGR_OFS_RESET: reg_rdata_o <= 8'h00;
          PGR_OFS_INT_TOP1: reg_rdata_o <= {drop_flag_r, 7'h00};
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule // pgr_power_good

/* File: test/pgr_power_good_props.sv */
`timescale 1ns/1ps
module pgr_power_good_props
  import pgr_pkg::*;
(
  // Clocking
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // System side
  input wire logic power_good_out_o,
  input wire logic otp_reload_o,
  input wire logic serial_if_reset_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic srst_wr;
  logic rd_on;
  assign srst_wr = clk_en_i && reg_wr_i && reg_addr_i == PGR_OFS_RESET && reg_wdata_i[0];
  assign rd_on = clk_en_i && reg_rd_i && !reg_wr_i;
  // ==========================================================
  // Soft reset
  AST_PULSE_PAIR: assert property (otp_reload_o == serial_if_reset_o)
    else $error("reload and interface reset pulses differ");
  AST_PULSE_CAUSE: assert property (otp_reload_o |-> $past(srst_wr))
    else $error("reload pulse without reset write");
  AST_SRST_PULSE: assert property (srst_wr |=> otp_reload_o ##1 !otp_reload_o)
    else $error("reset write did not give one pulse");
  AST_SRST_CTRL2: assert property (srst_wr ##1 !reg_wr_i ##1
    (rd_on && reg_addr_i == PGR_OFS_PG_CTRL2) |=> reg_rdata_o == 8'h04)
    else $error("control two not restored by soft reset");
  // ==========================================================
  // Read-back of fixed fields
  AST_RESET_READ: assert property (rd_on && reg_addr_i == PGR_OFS_RESET |=> reg_rdata_o == 8'h00)
    else $error("reset register read not zero");
  AST_CTRL2_RSV: assert property (rd_on && reg_addr_i == 8'h16 |=> reg_rdata_o[7:3] == 5'h00)
    else $error("control two reserved bits set");
  AST_FAULT_RSV: assert property (rd_on && reg_addr_i == 8'h17 |=> reg_rdata_o[7:4] == 4'h0)
    else $error("fault reserved bits set");
  AST_FLAG_RSV: assert property (rd_on && reg_addr_i == 8'h19 |=> reg_rdata_o[6:0] == 7'h00)
    else $error("flag register low bits set");
  cover property (srst_wr);
  cover property ($fell(power_good_out_o));
  cover property (rd_on && reg_addr_i == PGR_OFS_FAULT);
endmodule // pgr_power_good_props

bind pgr_power_good pgr_power_good_props chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .power_good_out_o(power_good_out_o),
  .otp_reload_o(otp_reload_o), .serial_if_reset_o(serial_if_reset_o));

/* File: test/pgr_host.sv */
`timescale 1ns/1ps
module pgr_host
  import pgr_pkg::*;
(
  // Clocking
  input wire logic sys_clk_i,
  // Register port
  input wire logic [7:0] reg_rdata_i,
  output pgr_req_type req_o
);
  initial begin
    req_o = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    req_o = '{1'b1, 1'b0, a, d};
    @(negedge sys_clk_i);
    // Released lines inverted so stale values never pass
    req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    req_o = '{1'b0, 1'b1, a, ~a};
    @(negedge sys_clk_i);
    req_o = '{1'b0, 1'b0, ~a, a};
    d = reg_rdata_i;
  endtask
  task automatic clear_fault(input logic [3:0] m);
    wr(8'h17, {4'h0, m});
  endtask
endmodule // pgr_host

/* File: test/pgr_power_good_test.sv */
`timescale 1ns/1ps
module pgr_power_good_test;
  import pgr_pkg::*;
  logic sys_clk_i;
  logic reset_i;
  logic clk_en;
  pgr_req_type req;
  pgr_mon_type mon;
  logic [7:0] rdata;
  logic pg;
  int failures;
  int tests_run;

  pgr_host host (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdata), .req_o(req));
  pgr_power_good dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .reg_wr_i(req.wr), .reg_rd_i(req.rd), .reg_addr_i(req.addr), .reg_wdata_i(req.wdata),
    .reg_rdata_o(rdata), .rail_valid_i(mon.valid), .thermal_warning_i(mon.twarn),
    .power_good_out_o(pg), .otp_reload_o(), .serial_if_reset_o());

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  // Sync chain plus output stage, with margin
  task automatic pchk(input logic exp);
    repeat (6) @(negedge sys_clk_i);
    chk({7'h00, pg}, {7'h00, exp});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_defaults();
    rchk(8'h15, 8'h73);
    rchk(8'h16, 8'h04);
    rchk(8'h17, 8'h00);
    rchk(8'h18, 8'h00);
    rchk(8'h20, 8'h00);
    pchk(1'b1);
    host.wr(8'h15, 8'hF3);
    pchk(1'b0);
    host.wr(8'h15, 8'h73);
    mon.valid[2] = 1'b0;
    pchk(1'b1);
    rchk(8'h17, 8'h00);
    mon.valid[2] = 1'b1;
  endtask
  task automatic t_fault();
    mon.valid[0] = 1'b0;
    pchk(1'b0);
    rchk(8'h17, 8'h01);
    rchk(8'h19, 8'h80);
    host.clear_fault(4'h1);
    rchk(8'h17, 8'h01);
    mon.valid[0] = 1'b1;
    host.wr(8'h16, 8'h06);
    pchk(1'b0);
    host.clear_fault(4'h1);
    rchk(8'h17, 8'h00);
    pchk(1'b1);
    host.wr(8'h19, 8'h80);
    rchk(8'h19, 8'h00);
  endtask
  task automatic t_twarn_mode();
    host.wr(8'h16, 8'h04);
    mon.twarn = 1'b1;
    pchk(1'b0);
    host.wr(8'h16, 8'hF8);
    pchk(1'b1);
    mon.twarn = 1'b0;
    host.wr(8'h16, 8'hFD);
    rchk(8'h16, 8'h05);
  endtask
  task automatic t_srst();
    mon.valid[1] = 1'b0;
    pchk(1'b0);
    rchk(8'h17, 8'h02);
    mon.valid[1] = 1'b1;
    host.wr(8'h15, 8'hF0);
    host.wr(8'h18, 8'h01);
    rchk(8'h16, 8'h04);
    rchk(8'h15, 8'h73);
    rchk(8'h17, 8'h00);
    rchk(8'h18, 8'h00);
    pchk(1'b1);
  endtask
  // Rail kept invalid through a soft reset; only continuous mode lets the output go
  task automatic t_gate();
    mon.valid[0] = 1'b0;
    pchk(1'b0);
    host.wr(8'h18, 8'h01);
    host.wr(8'h16, 8'h06);
    pchk(1'b0);
    rchk(8'h17, 8'h00);
    host.wr(8'h16, 8'h07);
    pchk(1'b0);
    rchk(8'h17, 8'h01);
    mon.valid[0] = 1'b1;
    pchk(1'b0);
    host.clear_fault(4'h1);
    rchk(8'h17, 8'h00);
    pchk(1'b1);
  endtask
  // Enable low must freeze writes and monitor sampling alike
  task automatic t_freeze();
    clk_en = 1'b0;
    host.wr(8'h15, 8'hF3);
    mon.valid[0] = 1'b0;
    pchk(1'b1);
    mon.valid[0] = 1'b1;
    clk_en = 1'b1;
    rchk(8'h15, 8'h73);
    pchk(1'b1);
    rchk(8'h17, 8'h00);
  endtask
  task automatic print_verdict();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    failures = 0;
    tests_run = 0;
    reset_i = 1'b1;
    clk_en = 1'b1;
    mon = '{4'hF, 1'b0};
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_i = 1'b0;
    t_defaults();
    t_fault();
    t_twarn_mode();
    t_srst();
    t_gate();
    t_freeze();
    print_verdict();
  end
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule // pgr_power_good_test
